// *** hw/snf_core.sv ***
// Purpose: Erase, bad block remap, table read and feature logic of a serial NAND device
// Assumes: Host drives link_clk_in only while cs_n_in is low; SI sampled on rising edge
// Notes: A whole frame is captured on the link clock and executed on clk_in at chip select rise
module snf_core #(
  parameter logic [snf_pkg::TMR_W-1:0] ERASE_CYC_P = snf_pkg::TMR_W'(snf_pkg::ERASE_CYC)
) (
  input  wire logic                      clk_in,
  input  wire logic                      nrst_in,
  input  wire logic                      link_clk_in,
  input  wire logic                      cs_n_in,
  input  wire logic                      si_in,
  input  wire logic                      wp_n_in,
  output logic                           so_out,
  output logic                           so_oe_out,
  output logic                           busy_out,
  output logic                           quad_en_out,
  output logic                           erase_go_out,
  output logic [snf_pkg::BLK_W-1:0]      erase_block_out
);

  snf_pkg::snf_core_type r;
  snf_pkg::snf_core_type next_r;
  logic [snf_pkg::CNT_W-1:0] cnt;
  logic [snf_pkg::CNT_W-1:0] next_cnt;
  snf_pkg::snf_cap_type c;
  snf_pkg::snf_cap_type next_c;
  snf_pkg::snf_out_type o;
  snf_pkg::snf_out_type next_o;

  logic       go;
  logic       wp_ok;
  logic       sr_lock;
  logic       hw_lock;
  logic       full;
  logic       is_erase;
  logic       is_remap;
  logic       is_setf;
  logic       hit;
  logic [7:0] stat;

  // Blocks covered by block protect: count doubles per step, top or bottom of array
  function automatic logic prot_hit(input logic [snf_pkg::BLK_W-1:0] blk, input logic [3:0] bp,
                                    input logic tb);
    logic [snf_pkg::BLK_W:0] span;
    logic [snf_pkg::BLK_W:0] b;
    b = {1'b0, blk};
    if (bp == 4'h0) begin
      span = '0;
    end else if (bp >= 4'hB) begin
      span = 11'h400;
    end else begin
      span = 11'h001 << (bp - 4'h1);
    end
    if (tb) begin
      prot_hit = b < span;
    end else begin
      prot_hit = b >= (11'h400 - span);
    end
  endfunction

  // Decode of the frame just ended, valid only at the chip select rise
  always_comb begin
    go       = r.cs_s[1] & ~r.cs_s[2];
    wp_ok    = r.wp_s[1];
    full     = r.used == 5'(snf_pkg::LINKS);
    hw_lock  = r.prot[snf_pkg::PR_WPE] & ~wp_ok;
    sr_lock  = ({r.prot[snf_pkg::PR_SRP1], r.prot[snf_pkg::PR_SRP0]} == 2'h2)
             | (({r.prot[snf_pkg::PR_SRP1], r.prot[snf_pkg::PR_SRP0]} == 2'h1) & ~wp_ok);
    is_erase = (c.op == snf_pkg::OP_ERASE) && (c.bits == snf_pkg::CNT_W'(snf_pkg::BITS_ERASE));
    is_remap = (c.op == snf_pkg::OP_REMAP) && (c.bits == snf_pkg::CNT_W'(snf_pkg::BITS_REMAP));
    is_setf  = ((c.op == snf_pkg::OP_SETF) || (c.op == snf_pkg::OP_SETF2))
             && (c.bits == snf_pkg::CNT_W'(snf_pkg::BITS_SETF));
    hit      = prot_hit(c.arg[snf_pkg::BLK_LSB +: snf_pkg::BLK_W], r.prot[snf_pkg::PR_BP +: 4],
                        r.prot[snf_pkg::PR_TB]);
    stat                    = '0;
    stat[snf_pkg::SB_BUSY]  = r.state == snf_pkg::ST_ERASE;
    stat[snf_pkg::SB_WEL]   = r.write_enable_latch;
    stat[snf_pkg::SB_EFAIL] = r.efail;
    stat[snf_pkg::SB_PFAIL] = r.pfail;
    stat[snf_pkg::SB_FULL]  = full;
  end

  // Command execution and self-timed erase
  always_comb begin
    next_r          = r;
    next_r.erase_go = 1'b0;
    next_r.cs_s     = {r.cs_s[1:0], cs_n_in};
    next_r.wp_s     = {r.wp_s[0], wp_n_in};
    next_r.view.prot = r.prot;
    next_r.view.conf = r.conf;
    next_r.view.stat = stat;
    next_r.view.tbl  = r.tbl;
    case (r.state)
      snf_pkg::ST_IDLE: begin
        if (go) begin
          if ((c.op == snf_pkg::OP_WRITE_ENABLE_CMD) && (c.bits == snf_pkg::CNT_W'(snf_pkg::BITS_OP))) begin
            next_r.write_enable_latch = 1'b1;
          end else if ((c.op == snf_pkg::OP_RESET) && (c.bits == snf_pkg::CNT_W'(snf_pkg::BITS_OP))) begin
            next_r.efail = 1'b0;
            next_r.pfail = 1'b0;
            next_r.conf[snf_pkg::CF_OTPE] = 1'b0;
          end else if (is_erase) begin
            next_r.efail = 1'b0;
            next_r.pfail = 1'b0;
            if (r.write_enable_latch) begin
              if (hw_lock || hit) begin
                next_r.efail = 1'b1;
              end else begin
                next_r.state     = snf_pkg::ST_ERASE;
                next_r.tmr       = ERASE_CYC_P - 1'b1;
                next_r.erase_go  = 1'b1;
                next_r.erase_blk = c.arg[snf_pkg::BLK_LSB +: snf_pkg::BLK_W];
              end
            end
          end else if (is_remap && r.write_enable_latch && !full && !hw_lock) begin
            next_r.tbl[r.used] = {snf_pkg::LINK_ON, c.arg[29:16], c.arg[15:0]};
            next_r.used        = r.used + 5'h01;
          end else if (is_setf && r.write_enable_latch && !sr_lock && !hw_lock) begin
            if (c.arg[15:8] == snf_pkg::FA_PROT) begin
              next_r.prot = (r.prot & ~snf_pkg::PROT_WMASK) | (c.arg[7:0] & snf_pkg::PROT_WMASK);
            end else if (c.arg[15:8] == snf_pkg::FA_CONF) begin
              next_r.conf = (r.conf & ~snf_pkg::CONF_WMASK) | (c.arg[7:0] & snf_pkg::CONF_WMASK);
            end
          end
        end
      end
      snf_pkg::ST_ERASE: begin
        // Every instruction except feature reads is dropped while busy; table reads return no data
        if (r.tmr == '0) begin
          next_r.state = snf_pkg::ST_IDLE;
          next_r.write_enable_latch   = 1'b0;
        end else begin
          next_r.tmr = r.tmr - 1'b1;
        end
      end
      default: begin
        next_r.state = snf_pkg::ST_IDLE;
      end
    endcase
  end

  // Core register with power-up values
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      r           <= '0;
      r.state     <= snf_pkg::ST_IDLE;
      r.prot      <= snf_pkg::PROT_RST;
      r.conf      <= snf_pkg::CONF_RST;
      r.cs_s      <= 3'h7;
      r.wp_s      <= 2'h3;
      r.view.prot <= snf_pkg::PROT_RST;
      r.view.conf <= snf_pkg::CONF_RST;
    end else begin
      r <= next_r;
    end
  end

  // Link bit counter, saturating; cleared by chip select high between frames
  always_comb begin
    next_cnt = (cnt == '1) ? cnt : cnt + 1'b1;
  end

  always_ff @(posedge link_clk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // Frame capture and two-flop view of the core registers
  always_comb begin
    next_c      = c;
    next_c.bits = next_cnt;
    if (cnt < snf_pkg::CNT_W'(snf_pkg::BITS_OP)) begin
      next_c.op = {c.op[6:0], si_in};
    end else begin
      next_c.arg = {c.arg[30:0], si_in};
    end
    if ((cnt >= snf_pkg::CNT_W'(snf_pkg::BITS_OP)) && (cnt < snf_pkg::CNT_W'(snf_pkg::BITS_ADR))) begin
      next_c.fa = {c.fa[6:0], si_in};
    end
    next_c.s1 = r.view;
    next_c.s2 = c.s1;
  end

  // Captured words stay put once chip select rises, so the core may read them
  always_ff @(posedge link_clk_in) begin
    c <= next_c;
  end

  // Read answers; data bit index counts from the sixteenth falling edge
  always_comb begin
    logic [snf_pkg::CNT_W-1:0] p;
    logic [7:0]                fb;
    logic                      rd_f;
    logic                      rd_t;
    p      = cnt - snf_pkg::CNT_W'(snf_pkg::BITS_ADR);
    fb     = 8'h00;
    rd_f   = (c.op == snf_pkg::OP_GETF) || (c.op == snf_pkg::OP_GETF2);
    rd_t   = (c.op == snf_pkg::OP_TABLE) && !c.s2.stat[snf_pkg::SB_BUSY];
    next_o = '0;
    if (c.fa == snf_pkg::FA_PROT) begin
      fb = c.s2.prot;
    end else if (c.fa == snf_pkg::FA_CONF) begin
      fb = c.s2.conf;
    end else if (c.fa == snf_pkg::FA_STAT) begin
      fb = c.s2.stat;
    end
    if (cnt >= snf_pkg::CNT_W'(snf_pkg::BITS_ADR)) begin
      if (rd_f) begin
        next_o.oe = 1'b1;
        next_o.so = fb[3'h7 - p[2:0]];
      end else if (rd_t) begin
        next_o.oe = 1'b1;
        if (p[9:5] < 5'(snf_pkg::LINKS)) begin
          next_o.so = c.s2.tbl[p[9:5]][5'h1F - p[4:0]];
        end
      end
    end
  end

  always_ff @(negedge link_clk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      o <= '0;
    end else begin
      o <= next_o;
    end
  end

  // Outputs
  assign so_out          = o.so;
  assign so_oe_out       = o.oe;
  assign busy_out        = r.state == snf_pkg::ST_ERASE;
  assign quad_en_out     = ~r.prot[snf_pkg::PR_WPE];
  assign erase_go_out    = r.erase_go;
  assign erase_block_out = r.erase_blk;

  // Checks on the clk_in side
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_erase_req;
    r.state == snf_pkg::ST_IDLE && go && is_erase && r.write_enable_latch && !hw_lock && !hit;
  endsequence

  sequence s_busy2;
    r.state == snf_pkg::ST_ERASE ##1 r.state == snf_pkg::ST_ERASE;
  endsequence

  property p_erase_no_wel;
    r.state == snf_pkg::ST_IDLE && go && is_erase && !r.write_enable_latch |=> r.state == snf_pkg::ST_IDLE && !r.efail;
  endproperty
  a_erase_no_wel: assert property (p_erase_no_wel) else $error("erase ran without write enable");

  property p_erase_len;
    $rose(r.state == snf_pkg::ST_ERASE) |-> $past(c.bits) == snf_pkg::CNT_W'(snf_pkg::BITS_ERASE);
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase started from wrong frame length");

  property p_erase_start;
    s_erase_req |=> s_busy2 ##0 r.erase_go == 1'b0 && r.view.stat[snf_pkg::SB_BUSY];
  endproperty
  a_erase_start: assert property (p_erase_start) else $error("erase did not go busy");

  property p_erase_end;
    r.state == snf_pkg::ST_ERASE && r.tmr == '0 |=> r.state == snf_pkg::ST_IDLE && !r.write_enable_latch ##1
      !r.view.stat[snf_pkg::SB_BUSY];
  endproperty
  a_erase_end: assert property (p_erase_end) else $error("erase end did not clear busy and latch");

  property p_erase_prot;
    r.state == snf_pkg::ST_IDLE && go && is_erase && r.write_enable_latch && hit |=> r.efail && r.state == snf_pkg::ST_IDLE;
  endproperty
  a_erase_prot: assert property (p_erase_prot) else $error("protected block erase not refused");

  property p_remap_wel;
    r.state == snf_pkg::ST_IDLE && go && is_remap && !r.write_enable_latch |=> $stable(r.used) && $stable(r.tbl);
  endproperty
  a_remap_wel: assert property (p_remap_wel) else $error("remap taken without write enable");

  property p_remap_add;
    r.state == snf_pkg::ST_IDLE && go && is_remap && r.write_enable_latch && !full && !hw_lock |=>
      r.used == $past(r.used) + 5'h01 && r.tbl[$past(r.used)][31:30] == snf_pkg::LINK_ON;
  endproperty
  a_remap_add: assert property (p_remap_add) else $error("remap link not added");

  property p_full;
    full |=> full && $stable(r.tbl) ##1 r.view.stat[snf_pkg::SB_FULL];
  endproperty
  a_full: assert property (p_full) else $error("full table changed or flag lost");

  property p_setf_mask;
    r.state == snf_pkg::ST_IDLE && go && is_setf |=>
      (r.conf & ~snf_pkg::CONF_WMASK) == ($past(r.conf) & ~snf_pkg::CONF_WMASK);
  endproperty
  a_setf_mask: assert property (p_setf_mask) else $error("read-only configuration bit changed");

  property p_busy_ignore;
    r.state == snf_pkg::ST_ERASE && r.tmr != '0 |=> $stable(r.prot) && $stable(r.conf) && $stable(r.used);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("instruction taken while busy");

endmodule // snf_core

// *** hw/snf_pkg.sv ***
// Purpose: Shared constants and types for the serial NAND erase, remap and feature logic
// Assumes: Single-bit serial transfers, bits sampled on rising link clock, shifted out on falling
// Notes: Status byte layout and configuration bit places are fixed here
// How it works
// - Opcode D8h plus 24-bit page address erases the addressed 64-page block to FFh.
// - Erase is ignored unless the write enable latch is 1.
// - Erase runs only if chip select rises right after the last address bit.
// - Busy reads 1 during the timed erase; status reads still answered; then 0.
// - Erase completion clears the write enable latch.
// - Erase of a block covered by block protect and top-bottom select is refused.
// - Remap is A1h, 16-bit bad block index, 16-bit replacement block index.
// - Remap accepted only while the write enable latch is 1.
// - Each remap adds one link, at most 20; then table full, further refused.
// - Table read is A5h plus eight dummy clocks; data from falling edge 16.
// - Links return in order from link 0; unused links read as zeros.
// - Bad block index bits 15:14 give link status; 10 means enabled and valid.
// - Feature reads 0Fh or 05h, writes 1Fh or 01h; A0h protection, B0h configuration.
// - Only write enable 06h sets the write enable latch; other status read-only.
// - Written features persist until rewritten; reset instruction FFh keeps them except configuration bit 6 (CF_OTPE), which it clears.
// - Writes change only the writable protection and configuration bits.
// - Power-up: block protect, top-bottom, ECC enable are 1; all else 0.
// - Status writes depend on status-protect bits, write enable and write-protect pin.
// - Block protect and top-bottom at bits 6 to 2; hardware-protect enable at bit 1.
// - Hardware-protect enable 1 disables quad functions; 0 allows them.
// - Erase on protected area sets erase-fail; erase or reset start clears fail flags.
// - Table full resets to 0 and becomes 1 once twenty links are used.
package snf_pkg;
  localparam logic [7:0] OP_ERASE   = 8'hD8;
  localparam logic [7:0] OP_REMAP   = 8'hA1;
  localparam logic [7:0] OP_TABLE   = 8'hA5;
  localparam logic [7:0] OP_GETF    = 8'h0F;
  localparam logic [7:0] OP_GETF2   = 8'h05;
  localparam logic [7:0] OP_SETF    = 8'h1F;
  localparam logic [7:0] OP_SETF2   = 8'h01;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD    = 8'h06;
  localparam logic [7:0] OP_RESET   = 8'hFF;
  localparam logic [7:0] FA_PROT    = 8'hA0;
  localparam logic [7:0] FA_CONF    = 8'hB0;
  localparam logic [7:0] FA_STAT    = 8'hC0;
  // Protection byte fields
  localparam int         PR_SRP0    = 0;
  localparam int         PR_WPE     = 1;
  localparam int         PR_TB      = 2;
  localparam int         PR_BP      = 3;
  localparam int         PR_SRP1    = 7;
  localparam logic [7:0] PROT_RST   = 8'h7C;
  localparam logic [7:0] PROT_WMASK = 8'hFF;
  // Configuration byte fields
  localparam int         CF_ECCE    = 4;
  localparam int         CF_OTPE    = 6;
  localparam int         CF_OTPL    = 7;
  localparam logic [7:0] CONF_RST   = 8'h10;
  localparam logic [7:0] CONF_WMASK = 8'hD0;
  // Result status byte fields
  localparam int         SB_BUSY    = 0;
  localparam int         SB_WEL     = 1;
  localparam int         SB_EFAIL   = 2;
  localparam int         SB_PFAIL   = 3;
  localparam int         SB_FULL    = 6;
  // Table and frame lengths in link clocks
  localparam int         LINKS      = 20;
  localparam int         LINK_W     = 32;
  localparam logic [1:0] LINK_ON    = 2'h2;
  localparam int         CNT_W      = 10;
  localparam int         BITS_OP    = 8;
  localparam int         BITS_ADR   = 16;
  localparam int         BITS_SETF  = 24;
  localparam int         BITS_ERASE = 32;
  localparam int         BITS_REMAP = 40;
  localparam int         BLK_LSB    = 6;
  localparam int         BLK_W      = 10;
  // Erase timing
  localparam int         CLK_MHZ    = 20;
  localparam int         ERASE_US   = 10000;
  localparam int         ERASE_CYC  = ERASE_US * CLK_MHZ;
  localparam int         TMR_W      = 18;

  typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_ERASE = 2'h2} snf_state_type;

  typedef logic [LINKS-1:0][LINK_W-1:0] snf_table_type;

  // Register view handed to the link domain
  typedef struct packed {
    logic [7:0]    prot;
    logic [7:0]    conf;
    logic [7:0]    stat;
    snf_table_type tbl;
  } snf_view_type;

  // Core state on clk_in
  typedef struct packed {
    snf_state_type   state;
    logic [7:0]      prot;
    logic [7:0]      conf;
    logic            write_enable_latch;
    logic            efail;
    logic            pfail;
    logic [4:0]      used;
    snf_table_type   tbl;
    logic [TMR_W-1:0] tmr;
    logic [2:0]      cs_s;
    logic [1:0]      wp_s;
    logic            erase_go;
    logic [BLK_W-1:0] erase_blk;
    snf_view_type    view;
  } snf_core_type;

  // Frame capture on the link clock
  typedef struct packed {
    logic [7:0]       op;
    logic [7:0]       fa;
    logic [31:0]      arg;
    logic [CNT_W-1:0] bits;
    snf_view_type     s1;
    snf_view_type     s2;
  } snf_cap_type;

  // Output stage on the falling link clock
  typedef struct packed {
    logic so;
    logic oe;
  } snf_out_type;
endpackage

// *** sim/snf_host.sv ***
// Purpose: Host serial controller model that sends frames to the NAND command logic
// Assumes: Mode 0, MSB first; link clock idles low and stands still between frames
// Notes: Each frame is followed by a chip select high gap long enough for the core to act
module snf_host (
  output logic      link_clk_out,
  output logic      cs_n_out,
  output logic      si_out,
  input  wire logic so_in
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int HALF_NS = 6;
  localparam int GAP_NS  = 300;

  // Idle levels before the first frame
  initial begin
    link_clk_out = 1'b0;
    cs_n_out     = 1'b1;
    si_out       = 1'b0;
  end

  // Send ntx bits, then clock in nrx bits; chip select rises right after the last clock
  task automatic xfer(input logic [47:0] tx, input int ntx, input int nrx, output logic [31:0] rx);
    rx = 32'h0;
    cs_n_out = 1'b0;
    #(HALF_NS);
    for (int i = ntx - 1; i >= 0; i--) begin
      si_out = tx[i];
      #(HALF_NS) link_clk_out = 1'b1;
      #(HALF_NS) link_clk_out = 1'b0;
    end
    for (int i = 0; i < nrx; i++) begin
      si_out = ~si_out; // Dummy input keeps toggling
      #(HALF_NS) link_clk_out = 1'b1;
      rx = {rx[30:0], so_in};
      #(HALF_NS) link_clk_out = 1'b0;
    end
    si_out = ~si_out;
    #(HALF_NS) cs_n_out = 1'b1;
    #(GAP_NS);
  endtask
endmodule // snf_host

// *** sim/tb_top.sv ***
// Purpose: Self-checking bench for erase, remap, table read and feature access
// Assumes: Erase time shortened to 100 core cycles; frames come from the host model
// Notes: Expected values follow the power-up defaults and field layout of the package
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic                      clk_in;
  logic                      nrst_in;
  logic                      wp_n_in;
  logic                      link_clk;
  logic                      cs_n;
  logic                      cs_q;
  logic                      si;
  logic                      so_out;
  logic                      so_oe_out;
  logic                      busy_out;
  logic                      quad_en_out;
  logic                      erase_go_out;
  logic [snf_pkg::BLK_W-1:0] erase_block_out;
  logic [31:0]               rx;
  int                        miscompares;
  int                        samples_checked;
  int                        go_count;
  int                        oe_idle;

  // Core clock
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  snf_core #(.ERASE_CYC_P(snf_pkg::TMR_W'(100))) dut_u (
    .clk_in          (clk_in),
    .nrst_in         (nrst_in),
    .link_clk_in     (link_clk),
    .cs_n_in         (cs_n),
    .si_in           (si),
    .wp_n_in         (wp_n_in),
    .so_out          (so_out),
    .so_oe_out       (so_oe_out),
    .busy_out        (busy_out),
    .quad_en_out     (quad_en_out),
    .erase_go_out    (erase_go_out),
    .erase_block_out (erase_block_out)
  );

  snf_host host_u (
    .link_clk_out (link_clk),
    .cs_n_out     (cs_n),
    .si_out       (si),
    .so_in        (so_out)
  );

  // Count erase starts and any drive while deselected
  always @(posedge clk_in) begin
    cs_q <= cs_n;
    if (erase_go_out === 1'b1)
      go_count++;
    if (cs_q === 1'b1 && cs_n === 1'b1 && so_oe_out === 1'b1)
      oe_idle++;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    chk("idle output enable", 32'h0, oe_idle);
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Frame helpers in the block's own serial protocol
  task automatic write_enable_cmd;
    host_u.xfer({40'h0, snf_pkg::OP_WRITE_ENABLE_CMD}, 8, 0, rx);
  endtask
  task automatic getf(input logic [7:0] op, input logic [7:0] fa);
    host_u.xfer({32'h0, op, fa}, 16, 8, rx);
  endtask
  task automatic setf(input logic [7:0] op, input logic [7:0] fa, input logic [7:0] d);
    host_u.xfer({24'h0, op, fa, d}, 24, 0, rx);
  endtask
  task automatic remap(input logic [15:0] b, input logic [15:0] r);
    host_u.xfer({8'h0, snf_pkg::OP_REMAP, b, r}, 40, 0, rx);
  endtask
  task automatic erase(input logic [23:0] a, input int n);
    host_u.xfer({16'h0, {snf_pkg::OP_ERASE, a} >> (32 - n)}, n, 0, rx);
  endtask
  task automatic tbl(input int n);
    host_u.xfer({32'h0, snf_pkg::OP_TABLE, 8'h00}, 16, 32 * (n + 1), rx);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy_out !== 1'b0 && n < 300) begin
      @(posedge clk_in);
      n++;
    end
    if (n == 300) begin
      miscompares++;
      test_done();
    end
  endtask

  // Main sequence
  initial begin
    nrst_in = 1'b0;
    wp_n_in = 1'b1;
    cs_q = 1'b1;
    miscompares = 0;
    samples_checked = 0;
    go_count = 0;
    oe_idle = 0;
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    getf(8'h0F, snf_pkg::FA_PROT);
    chk("prot reset", 32'h7C, rx);
    getf(8'h05, snf_pkg::FA_CONF);
    chk("conf reset", 32'h10, rx);
    getf(8'h0F, snf_pkg::FA_STAT);
    chk("stat reset", 32'h00, rx);
    chk("quad enable", 32'h1, quad_en_out);
    // Without write enable nothing is stored or erased
    remap(16'h0005, 16'h0300);
    tbl(0);
    chk("remap no wel", 32'h0, rx);
    erase(24'h000A40, 32);
    chk("erase no wel", 32'h0, go_count);
    // Whole array protected: erase refused with fail flag
    write_enable_cmd();
    getf(8'h0F, snf_pkg::FA_STAT);
    chk("wel set", 32'h02, rx);
    erase(24'h000A40, 32);
    chk("protected erase", 32'h0, go_count);
    getf(8'h0F, snf_pkg::FA_STAT);
    chk("erase fail", 32'h04, rx & 32'h05);
    write_enable_cmd();
    setf(8'h1F, snf_pkg::FA_PROT, 8'h00);
    getf(8'h0F, snf_pkg::FA_PROT);
    chk("prot write", 32'h00, rx);
    // Short frame must not erase
    write_enable_cmd();
    erase(24'h000A40, 31);
    chk("short erase", 32'h0, go_count);
    write_enable_cmd();
    erase(24'h000A40, 32);
    chk("erase start", 32'h1, go_count);
    chk("erase block", 32'h29, erase_block_out);
    getf(8'h0F, snf_pkg::FA_STAT);
    chk("busy status", 32'h01, rx & 32'h05);
    write_enable_cmd();
    remap(16'h0077, 16'h0777);
    wait_idle();
    getf(8'h0F, snf_pkg::FA_STAT);
    chk("erase done", 32'h00, rx);
    // Configuration write mask and reset persistence
    write_enable_cmd();
    setf(8'h01, snf_pkg::FA_CONF, 8'hEF);
    getf(8'h0F, snf_pkg::FA_CONF);
    chk("conf write", 32'hC0, rx);
    host_u.xfer({40'h0, snf_pkg::OP_RESET}, 8, 0, rx);
    getf(8'h0F, snf_pkg::FA_PROT);
    chk("prot kept", 32'h00, rx);
    getf(8'h0F, snf_pkg::FA_CONF);
    chk("conf kept", 32'h80, rx);
    // Hardware protect with the pin low blocks writes
    write_enable_cmd();
    setf(8'h1F, snf_pkg::FA_PROT, 8'h02);
    chk("quad off", 32'h0, quad_en_out);
    @(posedge clk_in);
    wp_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    write_enable_cmd();
    setf(8'h1F, snf_pkg::FA_PROT, 8'h7C);
    getf(8'h0F, snf_pkg::FA_PROT);
    chk("wp blocks", 32'h02, rx);
    @(posedge clk_in);
    wp_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    // Fill the table with distinct blocks, one extra attempt
    for (int i = 0; i < 21; i++) begin
      write_enable_cmd();
      remap(16'(i + 1), 16'(16'h0100 + i));
    end
    tbl(0);
    chk("link 0", 32'h8001_0100, rx);
    tbl(19);
    chk("link 19", 32'h8014_0113, rx);
    tbl(20);
    chk("past table", 32'h0, rx);
    getf(8'h0F, snf_pkg::FA_STAT);
    chk("table full", 32'h40, rx & 32'h40);
    test_done();
  end
endmodule // tb_top
